// *** design/ocm_clock_loss_monitor.sv ***
// Oscillator clock-loss monitor with divided and observation clock outputs.
// Assumes clk is the always-on RC reference clock and all inputs are synchronous to it.
//
// Notes on behaviour
// R1 - Monitor logic runs on the RC reference clock, not the watched oscillator.
// R2 - Nine reference periods without an oscillator toggle declare clock loss.
// R3 - On loss, switch reference to RC clock only if bit 8 enabled.
// R4 - Error output is driven low while clock loss is present.
// R5 - The external supervisor performs recovery; the monitor does none itself.
// R6 - Each system clock output is its system clock divided by four.
// R7 - System clock outputs have fixed sources with no selection.
// R8 - Observation outputs select one of several internal clocks, for debug only.
// R9 - A clock output pad works only when its receive-active bit is set.
// R10 - Clock loss stays latched with error low until reset.
`timescale 1ns/1ps

module ocm_clock_loss_monitor
(
   // Clock and reset.
   input  wire logic                                clk,
   input  wire logic                                arst_n,
   // Watched oscillator and system clocks, sampled as levels.
   input  wire logic                                main_osc_clock,
   input  wire logic                                system_clock_main,
   input  wire logic                                mcu_system_clock_main,
   // Configuration.
   input  wire logic [ocm_pkg::CLKSEL_WIDTH-1:0]    pll_clock_select_reg,
   input  wire logic [ocm_pkg::OBS_SEL_WIDTH-1:0]   observe_select,
   input  wire logic [ocm_pkg::OBS_SEL_WIDTH-1:0]   mcu_observe_select,
   input  wire logic                                main_pad_receive_active,
   input  wire logic                                mcu_pad_receive_active,
   // Status and fault report.
   output logic                                     clock_loss,
   output logic                                     ref_clock_select,
   output logic                                     error_out_n,
   // Clock outputs.
   output logic                                     sys_div4_clock_out,
   output logic                                     mcu_div4_clock_out,
   output logic                                     observe_clock_out,
   output logic                                     mcu_observe_clock_out
);

   // Rising edge of a sampled clock level.
   // The previous-sample flops reset low, the idle level of the sampled clocks, so no false edge follows reset.
   function automatic logic rise(input logic prev, input logic cur);
      rise = cur & ~prev;
   endfunction : rise

   // Picks one observation source for a given select code.
   function automatic logic obs_pick(input logic [ocm_pkg::OBS_SEL_WIDTH-1:0] sel,
                                     input logic osc, input logic sys, input logic mcu,
                                     input logic sdiv, input logic mdiv, input logic loss);
      case (sel)
         ocm_pkg::OBS_SEL_MAIN_OSC: obs_pick = osc;
         ocm_pkg::OBS_SEL_SYS:      obs_pick = sys;
         ocm_pkg::OBS_SEL_MCU_SYS:  obs_pick = mcu;
         ocm_pkg::OBS_SEL_SYS_DIV4: obs_pick = sdiv;
         ocm_pkg::OBS_SEL_MCU_DIV4: obs_pick = mdiv;
         ocm_pkg::OBS_SEL_LOSS:     obs_pick = loss;
         default:                   obs_pick = 1'b0;
      endcase
   endfunction : obs_pick

   logic                rst_meta;
   logic                rst_sync_n;
   logic                osc_prev;
   logic [3:0]          idle_count;
   logic [3:0]          next_idle_count;
   ocm_pkg::ocm_state_t state;
   ocm_pkg::ocm_state_t next_state;
   logic                sys_prev;
   logic                mcu_prev;
   logic                sys_half;
   logic                mcu_half;
   logic                sys_div4;
   logic                mcu_div4;

   // The oscillator is sampled as a level, so any difference between two samples counts as a toggle.
   // An oscillator near or above half the reference rate can alias and look stopped; the monitor only
   // promises to catch an oscillator that has really stopped.
   wire logic osc_toggled  = osc_prev ^ main_osc_clock;
   wire logic stop_reached = (idle_count == ocm_pkg::OSC_STOP_PERIODS);
   wire logic switch_en    = pll_clock_select_reg[ocm_pkg::LOSS_SWITCH_BIT];
   wire logic sys_rise     = rise(sys_prev, system_clock_main);
   wire logic mcu_rise     = rise(mcu_prev, mcu_system_clock_main);
   wire logic lost         = (state == ocm_pkg::OCM_LOST);
   wire logic obs_main     = obs_pick(observe_select, main_osc_clock, system_clock_main,
                                      mcu_system_clock_main, sys_div4, mcu_div4, lost);
   wire logic obs_mcu      = obs_pick(mcu_observe_select, main_osc_clock, system_clock_main,
                                      mcu_system_clock_main, sys_div4, mcu_div4, lost);

   // Reset release through two flip-flops.
   // Entry into reset is immediate; release waits two edges so no flop sees a release near its edge.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // R2 idle period count
   always_comb
   begin
      // The count saturates at the stop value so it cannot wrap and hide a stopped oscillator.
      if (osc_toggled)
         next_idle_count = ocm_pkg::IDLE_COUNT_ZERO;
      else if (stop_reached)
         next_idle_count = idle_count;
      else
         next_idle_count = idle_count + ocm_pkg::IDLE_COUNT_STEP;
   end

   // R10 latched loss state
   // Nothing but reset leaves the lost state, even if the oscillator comes back.
   always_comb
   begin
      case (state)
         ocm_pkg::OCM_RUNNING: next_state = stop_reached ? ocm_pkg::OCM_LOST : ocm_pkg::OCM_RUNNING;
         ocm_pkg::OCM_LOST:    next_state = ocm_pkg::OCM_LOST;
         default:              next_state = ocm_pkg::OCM_RUNNING;
      endcase
   end

   // R1 monitor on reference clock
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         osc_prev   <= 1'b0;
         idle_count <= ocm_pkg::IDLE_COUNT_ZERO;
         state      <= ocm_pkg::OCM_RUNNING;
      end
      else
      begin
         osc_prev   <= main_osc_clock;
         idle_count <= next_idle_count;
         state      <= next_state;
      end
   end

   // Fault outputs, registered one cycle after the loss state.
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         clock_loss       <= 1'b0;
         error_out_n      <= 1'b1;
         ref_clock_select <= ocm_pkg::REF_SEL_OSC;
      end
      else
      begin
         clock_loss  <= lost;
         // R4 error pin low
         error_out_n <= ~lost;
         // R3 switch to RC
         // The switch is one way until reset; an enable set after the loss acts on the next edge.
         if (lost && switch_en)
            ref_clock_select <= ocm_pkg::REF_SEL_RC;
      end
   end

   // R6 divide by four
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         sys_prev <= 1'b0;
         mcu_prev <= 1'b0;
         sys_half <= ocm_pkg::DIV4_COUNT_ZERO;
         mcu_half <= ocm_pkg::DIV4_COUNT_ZERO;
         sys_div4 <= 1'b0;
         mcu_div4 <= 1'b0;
      end
      else
      begin
         sys_prev <= system_clock_main;
         mcu_prev <= mcu_system_clock_main;
         if (sys_rise)
         begin
            sys_half <= ~sys_half;
            if (sys_half)
               sys_div4 <= ~sys_div4;
         end
         if (mcu_rise)
         begin
            mcu_half <= ~mcu_half;
            if (mcu_half)
               mcu_div4 <= ~mcu_div4;
         end
      end
   end

   // Pad outputs.
   // A pad whose receive-active bit is clear is held low rather than left toggling.
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         sys_div4_clock_out    <= 1'b0;
         mcu_div4_clock_out    <= 1'b0;
         observe_clock_out     <= 1'b0;
         mcu_observe_clock_out <= 1'b0;
      end
      else
      begin
         // R7 fixed sources
         // R9 receive active gating
         sys_div4_clock_out    <= sys_div4 & main_pad_receive_active;
         mcu_div4_clock_out    <= mcu_div4 & mcu_pad_receive_active;
         // R8 observation select
         observe_clock_out     <= obs_main & main_pad_receive_active;
         mcu_observe_clock_out <= obs_mcu & mcu_pad_receive_active;
      end
   end

endmodule : ocm_clock_loss_monitor

// *** design/ocm_pkg.sv ***
// Constants shared by the oscillator clock-loss monitor.
// Assumes the monitor runs on the always-on RC reference clock.
package ocm_pkg;

   // Reference clock rate and period of the monitor.
   localparam int unsigned CLK_HZ            = 25_000_000;
   localparam int unsigned CLK_PERIOD_NS     = 40;

   // Reference periods without a toggle that count as a stopped oscillator.
   localparam logic [3:0]  OSC_STOP_PERIODS  = 4'h9;
   localparam logic [3:0]  IDLE_COUNT_ZERO   = 4'h0;
   localparam logic [3:0]  IDLE_COUNT_STEP   = 4'h1;

   // Output clocks are the source divided by four: toggle every second rising edge.
   localparam logic        DIV4_COUNT_ZERO   = 1'b0;

   // Position of the loss switch enable in the clock select register.
   localparam int unsigned LOSS_SWITCH_BIT   = 8;
   localparam int unsigned CLKSEL_WIDTH      = 16;

   // Reference clock source encoding.
   localparam logic        REF_SEL_OSC       = 1'b0;
   localparam logic        REF_SEL_RC        = 1'b1;

   // Observation clock source selection.
   localparam int unsigned OBS_SEL_WIDTH     = 3;
   localparam logic [2:0]  OBS_SEL_OFF       = 3'h0;
   localparam logic [2:0]  OBS_SEL_MAIN_OSC  = 3'h1;
   localparam logic [2:0]  OBS_SEL_SYS       = 3'h2;
   localparam logic [2:0]  OBS_SEL_MCU_SYS   = 3'h3;
   localparam logic [2:0]  OBS_SEL_SYS_DIV4  = 3'h4;
   localparam logic [2:0]  OBS_SEL_MCU_DIV4  = 3'h5;
   localparam logic [2:0]  OBS_SEL_LOSS      = 3'h6;

   // Monitor states.
   typedef enum logic [0:0] {
      OCM_RUNNING,
      OCM_LOST
   } ocm_state_t;

endpackage : ocm_pkg

// *** tb/ocm_clock_loss_monitor_properties.sv ***
// Port assertions for the oscillator clock-loss monitor.
// Assumes one clock domain: clk with reset arst_n.
`timescale 1ns/1ps

module ocm_clock_loss_monitor_chk
(
   input  wire logic                             clk,
   input  wire logic                             arst_n,
   input  wire logic                             main_osc_clock,
   input  wire logic [ocm_pkg::CLKSEL_WIDTH-1:0] pll_clock_select_reg,
   input  wire logic                             main_pad_receive_active,
   input  wire logic                             clock_loss,
   input  wire logic                             ref_clock_select,
   input  wire logic                             error_out_n,
   input  wire logic                             sys_div4_clock_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence osc_quiet;
      $changed(main_osc_clock) ##1 $stable(main_osc_clock)[*8] ##1 $stable(main_osc_clock);
   endsequence

   chk_loss_deadline: assert property (osc_quiet |-> ##3 clock_loss)
      else $error("clock loss not flagged after nine quiet periods");
   chk_no_early_loss: assert property ((!clock_loss && $changed(main_osc_clock)) |=> !clock_loss[*8])
      else $error("clock loss flagged too early");
   chk_loss_sticky: assert property (clock_loss |=> clock_loss)
      else $error("clock loss cleared without reset");
   chk_error_pin_low: assert property (error_out_n == !clock_loss)
      else $error("error pin does not follow clock loss");
   chk_ref_needs_loss: assert property (ref_clock_select |-> clock_loss)
      else $error("reference switched without clock loss");
   chk_ref_enable_bit: assert property ($rose(clock_loss) |->
      ref_clock_select == $past(pll_clock_select_reg[ocm_pkg::LOSS_SWITCH_BIT]))
      else $error("reference switch disagrees with enable bit");
   chk_ref_late_enable: assert property ((clock_loss && !ref_clock_select &&
      pll_clock_select_reg[ocm_pkg::LOSS_SWITCH_BIT]) |-> ##[1:2] ref_clock_select)
      else $error("reference not switched after late enable");
   chk_pad_gate_off: assert property ((!main_pad_receive_active ##1 !main_pad_receive_active) |-> !sys_div4_clock_out)
      else $error("divided clock pad drives without receive active");
endmodule : ocm_clock_loss_monitor_chk

bind ocm_clock_loss_monitor ocm_clock_loss_monitor_chk i_chk (.clk(clk), .arst_n(arst_n),
   .main_osc_clock(main_osc_clock), .pll_clock_select_reg(pll_clock_select_reg),
   .main_pad_receive_active(main_pad_receive_active), .clock_loss(clock_loss),
   .ref_clock_select(ref_clock_select), .error_out_n(error_out_n), .sys_div4_clock_out(sys_div4_clock_out));

// *** tb/ocm_supervisor_model.sv ***
// Board supervisor: power-cycles the board once the error pin has stayed low.
// Assumes error_out_n is synchronous to clk.
`timescale 1ns/1ps

module ocm_supervisor_model
#(
   parameter int unsigned HOLD = 40
)
(
   input  wire logic clk,
   input  wire logic error_out_n,
   output logic      board_rst_n
);
   int unsigned low_cycles = 0;

   always @(posedge clk)
   begin
      low_cycles  <= error_out_n ? 0 : low_cycles + 1;
      board_rst_n <= !(low_cycles >= HOLD);
   end
endmodule : ocm_supervisor_model

// *** tb/test_ocm_clock_loss_monitor.sv ***
// Bench for the clock-loss monitor with a board supervisor model.
// Assumes a 25 MHz clk and synchronous stimulus.
`timescale 1ns/1ps

module test_ocm_clock_loss_monitor;
   logic        clk = 1'b0, rst_n = 1'b0, run = 1'b0, osc = 1'b0, sys = 1'b0, mcu = 1'b0, mra = 1'b1, cra = 1'b1;
   logic [15:0] cyc = 16'h0000, pll = 16'h0000, cnt [4];
   logic [2:0]  osel = 3'h0, msel = 3'h0;
   logic        loss, refsel, err_n, sd, md, ob, mob, board_rst_n;
   int          bad_count = 0, comparisons = 0;
   wire logic   arst_n = rst_n & board_rst_n;
   wire logic [3:0] outs = {ob, mob, sd, md};
   logic [15:0] obs_exp [8] = '{16'h0, 16'h10, 16'h10, 16'h8, 16'h4, 16'h2, 16'h0, 16'h0};

   ocm_clock_loss_monitor i_dut (.clk(clk), .arst_n(arst_n), .main_osc_clock(osc), .system_clock_main(sys),
      .mcu_system_clock_main(mcu), .pll_clock_select_reg(pll), .observe_select(osel), .mcu_observe_select(msel),
      .main_pad_receive_active(mra), .mcu_pad_receive_active(cra), .clock_loss(loss), .ref_clock_select(refsel),
      .error_out_n(err_n), .sys_div4_clock_out(sd), .mcu_div4_clock_out(md), .observe_clock_out(ob),
      .mcu_observe_clock_out(mob));
   ocm_supervisor_model i_sup (.clk(clk), .error_out_n(err_n), .board_rst_n(board_rst_n));

   initial forever #20 clk = ~clk;

   task automatic print_verdict();
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Counts output changes over sixteen cycles.
   task automatic tally();
      logic [3:0] last;
      repeat (3) @(negedge clk);
      cnt = '{default: 16'h0000};
      last = outs;
      repeat (16)
      begin
         @(negedge clk);
         for (int k = 0; k < 4; k++) cnt[k] += 16'(outs[k] ^ last[k]);
         last = outs;
      end
   endtask : tally

   always @(posedge clk)
   begin
      cyc <= cyc + 16'h0001;
      sys <= cyc[0];
      mcu <= cyc[1];
      if (run) osc <= cyc[0];
      if (cyc == 16'h0bb8)
      begin
         bad_count++;
         print_verdict();
      end
   end

   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      run <= 1'b1;
      for (int c = 0; c < 8; c++)
      begin
         @(posedge clk);
         osel <= 3'(c);
         msel <= 3'(c);
         tally();
         check(cnt[3], obs_exp[c]);
         check(cnt[2], obs_exp[c]);
      end
      check(cnt[1], 16'h0004);
      check(cnt[0], 16'h0002);
      $display("observe and divider test done");
      @(posedge clk);
      mra <= 1'b0;
      cra <= 1'b0;
      osel <= 3'h2;
      tally();
      check(cnt[0] | cnt[1] | cnt[2] | cnt[3], 16'h0000);
      check({12'h000, outs}, 16'h0000);
      $display("receive active test done");
      @(posedge clk);
      mra <= 1'b1;
      osel <= 3'h6;
      run <= 1'b0;
      repeat (12) @(negedge clk);
      check({15'h0000, loss}, 16'h0000);
      repeat (3) @(negedge clk);
      check({12'h000, loss, err_n, refsel, ob}, 16'h0009);
      @(posedge clk);
      run <= 1'b1;
      repeat (20) @(negedge clk);
      check({13'h0000, loss, err_n, refsel}, 16'h0004);
      @(posedge clk);
      pll <= 16'h0100;
      repeat (3) @(negedge clk);
      check({15'h0000, refsel}, 16'h0001);
      repeat (30) @(negedge clk);
      check({13'h0000, loss, err_n, refsel}, 16'h0002);
      $display("first loss test done");
      @(posedge clk);
      run <= 1'b0;
      repeat (15) @(negedge clk);
      check({14'h0000, loss, refsel}, 16'h0003);
      $display("switch enabled loss test done");
      print_verdict();
   end
endmodule : test_ocm_clock_loss_monitor
